// file: logic/usb_ep_dma_pkg.sv
/*
 * Shared constants for the endpoint receive DMA: widths, reset values,
 * transfer modes and FIFO depth.
 * Assumes nothing of its surroundings; compiled before the modules.
 */
package usb_ep_dma_pkg;
	localparam int DATA_W      = 8;
	localparam int SIZE_W      = 16;
	localparam int ADDR_W      = 32;
	localparam int FIFO_DEPTH  = 8;
	localparam logic [SIZE_W-1:0] SIZE_RST  = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;
	localparam logic [SIZE_W-1:0] COUNT_RST = 16'h0000;

	// Transfer modes, as picked by device software
	typedef enum logic {
		per_packet_transfer_mode,
		size_terminated_transfer_mode
	} xfer_mode_e;
endpackage

// file: logic/ep_rx_fifo.sv
/*
 * Receive FIFO between the USB packet side and the DMA write side.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module ep_rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             srst_i,
	// Fill side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// Drain side
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i,
	// Status
	output logic                  empty_o
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0]   count;
	} fifo_s;

	fifo_s              st;
	fifo_s              next_st;
	logic [WIDTH-1:0]   mem [DEPTH];
	logic               push;
	logic               pop;

	// Handshakes and flags
	assign in_ready_o  = (st.count != (PW+1)'(DEPTH));
	assign out_valid_o = (st.count != '0);
	assign empty_o     = (st.count == '0);
	assign out_data_o  = mem[st.rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Pointer and count update
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr_ptr = st.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_st.rd_ptr = st.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_st.count = st.count + 1'b1;
		end else if (pop && !push) begin
			next_st.count = st.count - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Storage
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[st.wr_ptr] <= in_data_i;
		end
	end
endmodule

// file: logic/usb_endpoint_dma_modes.sv
/*
 * Endpoint receive DMA of the first USB controller: packet bytes enter a
 * FIFO, the DMA writes them to memory one byte a beat and raises
 * completion pulses per packet or per whole transfer.
 * Assumes packet-side inputs come from logic on clk_sys_i and that the
 * memory side answers writes with a ready on the same clock.
 */
`timescale 1ns/1ps

// What this block does
// - Non-full FIFO accepts new data while dma_enable_i is set, DMA drains it.
// - Running transfer keeps size latched at start.
// - Per-packet: interrupt each packet; else once per transfer.
// - Isochronous: size equals packet, interrupt every packet.
module usb_endpoint_dma_modes (
	// Clock and reset
	input  wire logic                               clk_sys_i,
	input  wire logic                               srst_i,
	// Endpoint configuration from device software
	input  wire usb_ep_dma_pkg::xfer_mode_e         mode_i,
	input  wire logic                               iso_ep_i,
	input  wire logic [usb_ep_dma_pkg::SIZE_W-1:0]  xfer_size_i,
	input  wire logic [usb_ep_dma_pkg::ADDR_W-1:0]  base_addr_i,
	input  wire logic                               dma_enable_i,
	// Packet data from the USB link
	input  wire logic                               pkt_valid_i,
	input  wire logic [usb_ep_dma_pkg::DATA_W-1:0]  pkt_data_i,
	input  wire logic                               pkt_last_i,
	input  wire logic                               pkt_short_i,
	output logic                                    pkt_ready_o,
	// Memory write port
	output logic                                    mem_wr_o,
	output logic [usb_ep_dma_pkg::ADDR_W-1:0]       mem_addr_o,
	output logic [usb_ep_dma_pkg::DATA_W-1:0]       mem_data_o,
	input  wire logic                               mem_ready_i,
	// Events and status
	output logic                                    irq_o,
	output logic                                    busy_o
);
	// FIFO entry width and width of the occupancy count (0 to depth)
	localparam int FW = usb_ep_dma_pkg::DATA_W + 2;
	localparam int LW = $clog2(usb_ep_dma_pkg::FIFO_DEPTH) + 1;

	typedef struct packed {
		logic                               busy;
		logic [usb_ep_dma_pkg::SIZE_W-1:0]  size;
		logic                               batch;
		logic [usb_ep_dma_pkg::SIZE_W-1:0]  count;
		logic [usb_ep_dma_pkg::ADDR_W-1:0]  addr;
		logic                               wr;
		logic [usb_ep_dma_pkg::DATA_W-1:0]  wdata;
		logic                               wlast;
		logic                               wshort;
		logic                               irq;
		logic                               ready;
		logic [LW-1:0]                      fill;
	} dma_s;

	dma_s            st;
	dma_s            next_st;
	logic            f_in_ready;
	logic            f_valid;
	logic [FW-1:0]   f_data;
	logic            f_pop;
	logic            f_push;

	// Size-terminated batching applies only to non-isochronous endpoints
	function automatic logic batch_of(
		input usb_ep_dma_pkg::xfer_mode_e mode,
		input logic                       iso
	);
		return (mode == usb_ep_dma_pkg::size_terminated_transfer_mode) && !iso;
	endfunction

	// FIFO occupancy after this edge's push and pop
	function automatic logic [LW-1:0] fill_after(
		input logic [LW-1:0] fill,
		input logic          push,
		input logic          pop
	);
		logic [LW-1:0] f;
		f = fill;
		if (push && !pop) begin
			f = fill + 1'b1;
		end else if (pop && !push) begin
			f = fill - 1'b1;
		end
		return f;
	endfunction

	// Last write of a transfer. Per-packet and isochronous endpoints end on
	// every packet; a batch ends at the programmed size or on a short packet.
	// A size of zero only matches after the count wraps, so such a batch
	// in practice ends on a short packet.
	function automatic logic ends_xfer(
		input logic                              batch,
		input logic [usb_ep_dma_pkg::SIZE_W-1:0] count,
		input logic [usb_ep_dma_pkg::SIZE_W-1:0] size,
		input logic                              last,
		input logic                              short_pkt
	);
		logic [usb_ep_dma_pkg::SIZE_W-1:0] done;
		done = count + 1'b1;
		if (!batch) begin
			return last;
		end
		return (done == size) || (last && short_pkt);
	endfunction

	// Receive FIFO; link stalls when it is full
	ep_rx_fifo #(
		.WIDTH (FW),
		.DEPTH (usb_ep_dma_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.srst_i      (srst_i),
		.in_valid_i  (pkt_valid_i && st.ready),
		.in_data_i   ({pkt_short_i, pkt_last_i, pkt_data_i}),
		.in_ready_o  (f_in_ready),
		.out_valid_o (f_valid),
		.out_data_o  (f_data),
		.out_ready_i (f_pop),
		.empty_o     ()
	);

	// Take a byte while dma_enable_i is set and no write is pending or it is being accepted
	assign f_pop = f_valid && dma_enable_i && (!st.wr || mem_ready_i);

	// Byte taken from the link this edge
	assign f_push = pkt_valid_i && st.ready && f_in_ready;

	// DMA sequencing and event generation
	always_comb begin
		next_st = st;
		next_st.irq = 1'b0;
		// Ready looks one edge ahead, so a registered ready never overfills
		next_st.fill = fill_after(st.fill, f_push, f_pop);
		next_st.ready = dma_enable_i
			&& (next_st.fill != LW'(usb_ep_dma_pkg::FIFO_DEPTH));
		if (st.wr && mem_ready_i) begin
			next_st.wr = 1'b0;
			next_st.addr = st.addr + 1'b1;
			next_st.count = st.count + 1'b1;
			if (ends_xfer(st.batch, st.count, st.size, st.wlast, st.wshort)) begin
				next_st.irq = 1'b1;
				next_st.busy = 1'b0;
			end
		end
		if (f_pop) begin
			if (!next_st.busy) begin
				// Start of a transfer latches its parameters
				next_st.busy = 1'b1;
				next_st.size = xfer_size_i;
				next_st.batch = batch_of(mode_i, iso_ep_i);
				next_st.count = usb_ep_dma_pkg::COUNT_RST;
				next_st.addr = base_addr_i;
			end
			next_st.wr = 1'b1;
			next_st.wdata = f_data[usb_ep_dma_pkg::DATA_W-1:0];
			next_st.wlast = f_data[usb_ep_dma_pkg::DATA_W];
			next_st.wshort = f_data[usb_ep_dma_pkg::DATA_W+1];
		end
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st <= '0;
			st.size <= usb_ep_dma_pkg::SIZE_RST;
			st.addr <= usb_ep_dma_pkg::ADDR_RST;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flops
	assign pkt_ready_o = st.ready;
	assign mem_wr_o    = st.wr;
	assign mem_addr_o  = st.addr;
	assign mem_data_o  = st.wdata;
	assign irq_o       = st.irq;
	assign busy_o      = st.busy;
endmodule

// file: tb/usb_ep_dma_chk.sv
/* Port checker for usb_endpoint_dma_modes.
   Assumes one clock and a bind to every instance. */
`timescale 1ns/1ps
module usb_ep_dma_chk (
	input wire logic        clk_sys_i,
	input wire logic        srst_i,
	input wire logic        pkt_valid_i,
	input wire logic        pkt_ready_o,
	input wire logic        mem_wr_o,
	input wire logic        mem_ready_i,
	input wire logic [31:0] mem_addr_o,
	input wire logic [7:0]  mem_data_o,
	input wire logic        irq_o,
	input wire logic        busy_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// Accepted memory write
	sequence s_wr_acc;
		mem_wr_o && mem_ready_i;
	endsequence
	// Write handshake, framing and completion pulse
	a_write_hold: assert property (
		mem_wr_o && !mem_ready_i |=> mem_wr_o && $stable(mem_addr_o) && $stable(mem_data_o))
		else $error("write dropped before accept");
	a_take_write: assert property (
		pkt_valid_i && pkt_ready_o && !busy_o && !mem_wr_o |-> ##[1:3] mem_wr_o)
		else $error("taken byte not written");
	a_write_busy: assert property (mem_wr_o |-> busy_o)
		else $error("write outside transfer");
	a_irq_cause: assert property (irq_o |-> $past(mem_wr_o && mem_ready_i))
		else $error("irq without accepted write");
	a_irq_single: assert property (
		s_wr_acc ##1 irq_o |-> (!busy_o || mem_wr_o)
		##1 (!irq_o || $past(mem_wr_o && mem_ready_i)))
		else $error("irq not a single ending pulse");
endmodule
bind usb_endpoint_dma_modes usb_ep_dma_chk u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
	.pkt_valid_i(pkt_valid_i), .pkt_ready_o(pkt_ready_o), .mem_wr_o(mem_wr_o),
	.mem_ready_i(mem_ready_i), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
	.irq_o(irq_o), .busy_o(busy_o));

// file: tb/link_host_model.sv
/* Link-side host model: sends packet bytes on valid/ready.
   Assumes calls start just after a clock edge. */
`timescale 1ns/1ps
module link_host_model (
	input  wire logic       clk_sys_i,
	input  wire logic       pkt_ready_o,
	output logic            pkt_valid_i,
	output logic [7:0]      pkt_data_i,
	output logic            pkt_last_i,
	output logic            pkt_short_i
);
	initial begin
		pkt_valid_i = 1'b0;
		pkt_data_i = 8'h00;
		pkt_last_i = 1'b0;
		pkt_short_i = 1'b0;
	end
	// One packet of bytes b, b+1, ..., each held until taken
	task automatic send(input int n, input logic sh, input logic [7:0] b);
		for (int k = 0; k < n; k++) begin
			@(negedge clk_sys_i);
			pkt_valid_i = 1'b1;
			pkt_data_i = b + k[7:0];
			pkt_last_i = (k == n - 1);
			pkt_short_i = sh;
			while (!pkt_ready_o) @(negedge clk_sys_i);
			@(posedge clk_sys_i);
		end
		@(negedge clk_sys_i);
		pkt_valid_i = 1'b0;
		pkt_data_i = ~pkt_data_i; // Released line shows no stale byte
	endtask
endmodule

// file: tb/testbench.sv
/* Self-checking bench for usb_endpoint_dma_modes.
   Assumes the checker and link model are compiled first. */
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i, srst_i, iso_ep_i, dma_enable_i, hold;
	logic mem_ready_i = 1'b0;
	usb_ep_dma_pkg::xfer_mode_e mode_i;
	logic [15:0] xfer_size_i;
	logic [31:0] base_addr_i, mem_addr_o;
	logic [7:0] pkt_data_i, mem_data_o, b;
	logic pkt_valid_i, pkt_last_i, pkt_short_i, pkt_ready_o, mem_wr_o, irq_o, busy_o;
	int num_errors = 0, n_compared = 0, seed = 32'h091d, idx = 0, irqs = 0;
	logic [7:0] exp_q[$];
	usb_endpoint_dma_modes DUT (.clk_sys_i, .srst_i, .mode_i, .iso_ep_i, .xfer_size_i,
		.base_addr_i, .dma_enable_i, .pkt_valid_i, .pkt_data_i, .pkt_last_i, .pkt_short_i,
		.pkt_ready_o, .mem_wr_o, .mem_addr_o, .mem_data_o, .mem_ready_i, .irq_o, .busy_o);
	link_host_model host (.clk_sys_i, .pkt_ready_o, .pkt_valid_i, .pkt_data_i, .pkt_last_i,
		.pkt_short_i);
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// Memory stalls at random, or fully while hold is set
	always @(negedge clk_sys_i) mem_ready_i = !hold && ($random(seed) % 2 != 0);
	// Score each accepted write and count completions
	always @(posedge clk_sys_i) begin
		if (irq_o) idx = 0;
		if (irq_o) irqs++;
		if (mem_wr_o && mem_ready_i) begin
			check(mem_data_o, exp_q.pop_front());
			check(mem_addr_o, base_addr_i + idx);
			idx++;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	// Configure, send n packets, change size after the first packet, wait idle, count irqs
	task automatic run(input logic m, input logic iso, input int size, input int n,
		input int len, input logic sh, input int want);
		mode_i = usb_ep_dma_pkg::xfer_mode_e'(m);
		iso_ep_i = iso;
		xfer_size_i = size[15:0];
		irqs = 0;
		for (int p = 0; p < n; p++) begin
			b = 8'($random(seed));
			for (int k = 0; k < len; k++) exp_q.push_back(b + k[7:0]);
			host.send(len, sh, b);
			xfer_size_i = size[15:0] ^ 16'h0004;
		end
		repeat (300) if (exp_q.size() != 0 || busy_o) @(negedge clk_sys_i);
		repeat (3) @(negedge clk_sys_i);
		check(irqs, want);
		check(busy_o, 32'h0000_0000);
		$display("test done m=%0d iso=%0d size=%0d", m, iso, size);
	endtask
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Stall memory so the FIFO fills and refuses
	initial begin
		hold = 1'b1;
		repeat (47) @(negedge clk_sys_i);
		check(pkt_ready_o, 32'h0000_0000);
		hold = 1'b0;
	end
	initial begin
		#3_000_000;
		num_errors++;
		complete_run();
	end
	initial begin
		srst_i = 1'b1;
		dma_enable_i = 1'b1;
		base_addr_i = 32'h0000_1000;
		mode_i = usb_ep_dma_pkg::per_packet_transfer_mode;
		iso_ep_i = 1'b0;
		xfer_size_i = 16'h0000;
		repeat (8) @(negedge clk_sys_i);
		srst_i = 1'b0;
		run(0, 0, 0, 2, 12, 0, 2);
		for (int r = 0; r < 4; r++) run(0, 0, 0, 3, 1 + ($random(seed) & 7), 0, 3);
		run(1, 0, 10, 2, 5, 0, 1);
		run(1, 0, 8, 4, 2, 0, 1);
		run(1, 0, 20, 1, 3, 1, 1);
		run(1, 1, 100, 3, 4, 0, 3);
		complete_run();
	end
endmodule
